// file: rtl/mcc_top.sv
// module: master clock synthesizer and host/hardware mode configuration
//
// Overview of operation
// - one master clock is produced at either the t1 or the e1 line rate.
// - all eight channels take the same line rate, no mixing of t1 and e1.
// - codes 000/001 use the e1 or t1 reference; rate 0 gives 2048 khz, rate 1 gives 1544 khz.
// - codes 010..111 take 8..256 khz on the e1 input, ignore the t1 input, rate picks output.
// - the output rate select comes from the five-bit equalizer control.
// - host mode uses the parallel port unless the host port select input is high.
// - the serial port uses the serial host clock as its transfer timing.
// - serial reads return register contents on the serial host output.
// - in hardware mode resistor, termination, equalizer and rx/tx termination are global.
// - in hardware mode the jitter attenuator path is one shared setting.
// - in hardware mode qrss is not offered while all-ones still is.
// - in hardware mode dual loopback is refused; other loopbacks remain.
// - in host mode each channel keeps its own build-out with one shared line rate.
`timescale 1ns/1ps
module mcc_top #(
    parameter int unsigned NUM_CH = 8
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // reference clocks and straps
    input wire logic e1_ref_clock_in,
    input wire logic t1_ref_clock_in,
    input wire mcc_pkg::mcc_strap_t strap_in,
    input wire logic hw_mode_in,
    input wire logic host_port_select_in,
    // serial host port
    input wire logic serial_host_clk_in,
    input wire logic serial_host_in,
    output logic serial_host_out,
    output logic serial_host_out_oe_out,
    // outputs
    output logic master_clk_out,
    output logic output_rate_select_out,
    output logic serial_port_active_out,
    output mcc_pkg::mcc_chan_cfg_t [NUM_CH-1:0] chan_cfg_out
);
    import mcc_pkg::*;

    if (NUM_CH != MCC_NUM_CH) begin : g_ch_check
        $error("channel count must be eight");
    end

    typedef struct packed {
        logic [31:0] ctrl;
        logic [NUM_CH-1:0][17:0] chan;
        logic [31:0] rdata;
        logic err;
        logic ack;
        logic e1_ref_d;
        logic t1_ref_d;
        logic sclk_d;
        logic [15:0] ser_shift;
        logic [4:0] ser_cnt;
        logic ser_out;
        logic ser_oe;
        mcc_chan_cfg_t [NUM_CH-1:0] cfg;
    } mcc_st_t;

    mcc_st_t st_q;
    mcc_st_t st_d;

    // ==========================================
    // mode and rate selection
    // ==========================================
    logic host_mode;
    logic [2:0] ref_sel;
    logic [4:0] eqc_global;
    logic rate_sel;
    logic ref_edge;
    logic ser_sel;
    logic [31:0] inc;
    logic ref_seen;
    logic [2:0] ser_idx;

    assign host_mode = !hw_mode_in;
    assign ref_sel = host_mode ? st_q.ctrl[MCC_CTRL_SEL +: 3] : strap_in.ref_freq_select;
    assign eqc_global = host_mode ? st_q.ctrl[MCC_CTRL_EQC +: 5] : strap_in.equalizer_control;
    // rate 1 selects t1; derived from equalizer control, no own pin
    assign rate_sel = !eqc_global[MCC_EQC_E1_BIT];
    assign ser_sel = host_mode && host_port_select_in;
    // channel named by the low command bits, last one still on the input
    assign ser_idx = {st_q.ser_shift[1:0], serial_host_in};
    // output rate chosen by rate select only, whichever reference is used
    assign inc = rate_sel ? MCC_INC_T1 : MCC_INC_E1;
    // codes other than 001 watch the e1 input; t1 input ignored there
    always_comb begin
        if (ref_sel == MCC_SEL_HI_T1) begin
            ref_edge = t1_ref_clock_in && !st_q.t1_ref_d;
        end else begin
            ref_edge = e1_ref_clock_in && !st_q.e1_ref_d;
        end
    end

    mcc_ref_div u_div (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .inc_in(inc),
        .ref_edge_in(ref_edge),
        .mclk_out(master_clk_out),
        .ref_seen_out(ref_seen)
    );

    // ==========================================
    // apb decode
    // ==========================================
    logic acc;
    logic wr;
    logic ch_hit;
    logic mapped;
    logic [2:0] ch_idx;
    logic [31:0] rd_val;

    assign acc = psel && penable;
    // one wait state: read data registered in the first access cycle
    assign wr = acc && st_q.ack && pwrite;
    assign ch_hit = paddr >= MCC_ADDR_CH_BASE && paddr < 8'(MCC_ADDR_CH_BASE + 4 * NUM_CH)
        && paddr[1:0] == 2'h0;
    assign mapped = paddr == MCC_ADDR_CTRL || paddr == MCC_ADDR_STAT || ch_hit;
    assign ch_idx = 3'((paddr - MCC_ADDR_CH_BASE) >> 2);

    always_comb begin
        rd_val = 32'h0000_0000;
        if (paddr == MCC_ADDR_CTRL) begin
            rd_val = st_q.ctrl;
        end else if (paddr == MCC_ADDR_STAT) begin
            rd_val = {28'h000_0000, ref_seen, ser_sel, host_mode, rate_sel};
        end else if (ch_hit) begin
            rd_val = {14'h0000, st_q.chan[ch_idx]};
        end
    end

    // ==========================================
    // state update
    // ==========================================
    always_comb begin
        st_d = st_q;
        st_d.e1_ref_d = e1_ref_clock_in;
        st_d.t1_ref_d = t1_ref_clock_in;
        st_d.sclk_d = serial_host_clk_in;
        st_d.err = 1'b0;
        st_d.ack = acc && !st_q.ack;
        if (acc && !st_q.ack) begin
            st_d.rdata = rd_val;
            st_d.err = !mapped;
        end
        if (wr && paddr == MCC_ADDR_CTRL) begin
            st_d.ctrl = pwdata;
        end
        if (wr && ch_hit) begin
            st_d.chan[ch_idx] = pwdata[17:0];
        end
        // serial port: shift on serial clock rising edge, 24-bit frame
        if (!ser_sel) begin
            st_d.ser_cnt = 5'h00;
            st_d.ser_oe = 1'b0;
        end else if (serial_host_clk_in && !st_q.sclk_d) begin
            st_d.ser_shift = {st_q.ser_shift[14:0], serial_host_in};
            st_d.ser_cnt = st_q.ser_cnt + 5'h01;
            if (st_q.ser_cnt == 5'h07 && st_q.ser_shift[5]) begin
                // read command: command bit 6; first data bit leaves at once
                st_d.ser_oe = 1'b1;
                st_d.ser_out = st_q.chan[ser_idx][15];
                st_d.ser_shift = {st_q.chan[ser_idx][14:0], 1'b0};
            end
            if (st_q.ser_oe) begin
                st_d.ser_out = st_q.ser_shift[15];
            end
            if (st_q.ser_cnt == 5'h17) begin
                st_d.ser_cnt = 5'h00;
                st_d.ser_oe = 1'b0;
            end
        end
        // per-channel effective configuration
        for (int i = 0; i < NUM_CH; i++) begin
            if (host_mode) begin
                st_d.cfg[i].rx_ext_resistor_select = st_q.chan[i][MCC_CH_RES +: 2];
                st_d.cfg[i].termination_impedance_select = st_q.chan[i][MCC_CH_TER +: 2];
                st_d.cfg[i].jitter_path_select = st_q.chan[i][MCC_CH_JA +: 2];
                st_d.cfg[i].rx_termination_enable = st_q.chan[i][MCC_CH_RXT];
                st_d.cfg[i].tx_termination_enable = st_q.chan[i][MCC_CH_TXT];
                // own build-out per channel, rate bit forced common
                st_d.cfg[i].equalizer_control = st_q.chan[i][MCC_CH_EQC +: 5];
                st_d.cfg[i].equalizer_control[MCC_EQC_E1_BIT] = !rate_sel;
                st_d.cfg[i].transmit_all_ones =
                    st_q.chan[i][MCC_CH_PAT +: 2] == MCC_PAT_TRANSMIT_ALL_ONES;
                st_d.cfg[i].qrss_enable = st_q.chan[i][MCC_CH_PAT +: 2] == MCC_PAT_QRSS;
                // every loopback, dual included, selectable per channel
                st_d.cfg[i].loopback = st_q.chan[i][MCC_CH_LOOP +: 3];
            end else begin
                st_d.cfg[i].rx_ext_resistor_select = strap_in.rx_ext_resistor_select;
                st_d.cfg[i].termination_impedance_select =
                    strap_in.termination_impedance_select;
                st_d.cfg[i].jitter_path_select = strap_in.jitter_path_select;
                st_d.cfg[i].rx_termination_enable = strap_in.rx_termination_enable;
                st_d.cfg[i].tx_termination_enable = strap_in.tx_termination_enable;
                st_d.cfg[i].equalizer_control = strap_in.equalizer_control;
                st_d.cfg[i].transmit_all_ones = strap_in.transmit_all_ones;
                st_d.cfg[i].qrss_enable = 1'b0;
                // loopback codes from the channel register; dual never offered
                st_d.cfg[i].loopback = {1'b0, st_q.chan[i][MCC_CH_LOOP +: 2]};
            end
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================
    // outputs
    // ==========================================
    assign prdata = st_q.rdata;
    assign pready = st_q.ack;
    assign pslverr = st_q.ack && st_q.err;
    assign serial_host_out = st_q.ser_out;
    assign serial_host_out_oe_out = st_q.ser_oe;
    assign output_rate_select_out = rate_sel;
    assign serial_port_active_out = ser_sel;
    assign chan_cfg_out = st_q.cfg;
endmodule

// file: common/mcc_pkg.sv
// package: constants and carriers for master clock and mode configuration
package mcc_pkg;
    // ==========================================
    // rates and timing
    // ==========================================
    localparam int unsigned MCC_SYS_CLK_KHZ = 40000;
    localparam int unsigned MCC_E1_KHZ = 2048;
    localparam int unsigned MCC_T1_KHZ = 1544;
    localparam int unsigned MCC_NUM_CH = 8;
    localparam int unsigned MCC_PHASE_W = 32;
    // phase increments: out_khz * 2^32 / sys_khz
    localparam logic [31:0] MCC_INC_E1 =
        32'((64'(MCC_E1_KHZ) << 32) / 64'(MCC_SYS_CLK_KHZ));
    localparam logic [31:0] MCC_INC_T1 =
        32'((64'(MCC_T1_KHZ) << 32) / 64'(MCC_SYS_CLK_KHZ));
    // ==========================================
    // reference select codes
    // ==========================================
    localparam logic [2:0] MCC_SEL_HI_E1 = 3'h0;
    localparam logic [2:0] MCC_SEL_HI_T1 = 3'h1;
    localparam logic [2:0] MCC_SEL_8K = 3'h2;
    localparam logic [2:0] MCC_SEL_16K = 3'h3;
    localparam logic [2:0] MCC_SEL_56K = 3'h4;
    localparam logic [2:0] MCC_SEL_64K = 3'h5;
    localparam logic [2:0] MCC_SEL_128K = 3'h6;
    localparam logic [2:0] MCC_SEL_256K = 3'h7;
    // equalizer codes with bit 3 set select the e1 rate (t1 otherwise)
    localparam int unsigned MCC_EQC_E1_BIT = 3;
    // ==========================================
    // apb register map
    // ==========================================
    localparam logic [7:0] MCC_ADDR_CTRL = 8'h00;
    localparam logic [7:0] MCC_ADDR_STAT = 8'h04;
    localparam logic [7:0] MCC_ADDR_CH_BASE = 8'h10;
    // ctrl fields
    localparam int unsigned MCC_CTRL_HOST = 0;
    localparam int unsigned MCC_CTRL_SEL = 4;
    localparam int unsigned MCC_CTRL_EQC = 8;
    localparam logic [31:0] MCC_CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] MCC_CH_RST = 16'h0000;
    // per-channel fields
    localparam int unsigned MCC_CH_RES = 0;
    localparam int unsigned MCC_CH_TER = 2;
    localparam int unsigned MCC_CH_JA = 4;
    localparam int unsigned MCC_CH_RXT = 6;
    localparam int unsigned MCC_CH_TXT = 7;
    localparam int unsigned MCC_CH_EQC = 8;
    localparam int unsigned MCC_CH_PAT = 13;
    localparam int unsigned MCC_CH_LOOP = 15;
    // tx pattern and loopback encodings
    localparam logic [1:0] MCC_PAT_NONE = 2'h0;
    localparam logic [1:0] MCC_PAT_TRANSMIT_ALL_ONES = 2'h1;
    localparam logic [1:0] MCC_PAT_QRSS = 2'h2;
    localparam logic [2:0] MCC_LB_NONE = 3'h0;
    localparam logic [2:0] MCC_LB_ANALOG = 3'h1;
    localparam logic [2:0] MCC_LB_REMOTE = 3'h2;
    localparam logic [2:0] MCC_LB_DIGITAL = 3'h3;
    localparam logic [2:0] MCC_LB_DUAL = 3'h4;

    // per-channel line configuration
    typedef struct packed {
        logic [1:0] rx_ext_resistor_select;
        logic [1:0] termination_impedance_select;
        logic [1:0] jitter_path_select;
        logic rx_termination_enable;
        logic tx_termination_enable;
        logic [4:0] equalizer_control;
        logic transmit_all_ones;
        logic qrss_enable;
        logic [2:0] loopback;
    } mcc_chan_cfg_t;

    // hardware-mode strap pins
    typedef struct packed {
        logic [1:0] rx_ext_resistor_select;
        logic [1:0] termination_impedance_select;
        logic [1:0] jitter_path_select;
        logic rx_termination_enable;
        logic tx_termination_enable;
        logic [4:0] equalizer_control;
        logic transmit_all_ones;
        logic [2:0] ref_freq_select;
    } mcc_strap_t;

    // serial host port wiring
    typedef struct packed {
        logic serial_host_clk;
        logic serial_host_in;
        logic serial_host_out;
        logic serial_host_out_oe;
    } mcc_ser_t;
endpackage

// file: rtl/mcc_ref_div.sv
// module: sticky reference edge seen flag and master clock phase accumulator
`timescale 1ns/1ps
module mcc_ref_div (
    // clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // control
    input wire logic [31:0] inc_in,
    input wire logic ref_edge_in,
    // outputs
    output logic mclk_out,
    output logic ref_seen_out
);
    import mcc_pkg::*;

    typedef struct packed {
        logic [MCC_PHASE_W-1:0] phase;
        logic seen;
    } mcc_div_st_t;

    mcc_div_st_t st_q;
    mcc_div_st_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.phase = st_q.phase + inc_in;
        if (ref_edge_in) begin
            st_d.seen = 1'b1;
        end
    end

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign mclk_out = st_q.phase[MCC_PHASE_W-1];
    assign ref_seen_out = st_q.seen;
endmodule

// file: tb/mcc_top_props.sv
// checker: port-level properties of the master clock block
`timescale 1ns/1ps
module mcc_top_props
    import mcc_pkg::*;
#(
    parameter int unsigned NUM_CH = 8
) (
    // clock, reset, apb
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // straps and outputs
    input wire mcc_strap_t strap_in,
    input wire logic hw_mode_in,
    input wire logic host_port_select_in,
    input wire logic serial_host_out_oe_out,
    input wire logic master_clk_out,
    input wire logic output_rate_select_out,
    input wire logic serial_port_active_out,
    input wire mcc_chan_cfg_t [NUM_CH-1:0] chan_cfg_out
);
    logic hw_q;
    mcc_strap_t strap_q;
    logic glob_ok;
    logic qrss_any;
    logic dual_any;
    logic unmapped;
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);
    // ==========================================
    // helper logic
    // ==========================================
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            hw_q <= 1'b0;
            strap_q <= '0;
        end else begin
            hw_q <= hw_mode_in;
            strap_q <= strap_in;
        end
    end
    always_comb begin
        glob_ok = 1'b1;
        qrss_any = 1'b0;
        dual_any = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            glob_ok &= (chan_cfg_out[i][17:4] == strap_q[16:3]);
            qrss_any |= chan_cfg_out[i].qrss_enable;
            dual_any |= (chan_cfg_out[i].loopback == MCC_LB_DUAL);
        end
    end
    assign unmapped = !(paddr == MCC_ADDR_CTRL || paddr == MCC_ADDR_STAT ||
        (paddr >= MCC_ADDR_CH_BASE && paddr < 8'(MCC_ADDR_CH_BASE + 4 * NUM_CH)
        && paddr[1:0] == 2'h0));
    // ==========================================
    // properties
    // ==========================================
    chk_rate_from_eqc: assert property (
        hw_mode_in && hw_q && $stable(strap_in)
        |-> output_rate_select_out == !strap_in.equalizer_control[MCC_EQC_E1_BIT])
        else $error("rate select does not follow equalizer control");
    chk_serial_select: assert property (
        serial_port_active_out == (!hw_mode_in && host_port_select_in))
        else $error("serial port selection wrong");
    chk_hw_global: assert property (hw_mode_in && hw_q |-> glob_ok)
        else $error("hardware mode setting not global");
    chk_hw_no_qrss: assert property (hw_mode_in && hw_q |-> !qrss_any)
        else $error("qrss active in hardware mode");
    chk_hw_no_dual: assert property (hw_mode_in && hw_q |-> !dual_any)
        else $error("dual loopback in hardware mode");
    chk_oe_idle: assert property (
        !serial_port_active_out [*2] |=> !serial_host_out_oe_out)
        else $error("serial output driven while port inactive");
    chk_mclk_high: assert property ($rose(master_clk_out) |-> ##[9:13] $fell(master_clk_out))
        else $error("master clock high phase out of range");
    chk_mclk_low: assert property ($fell(master_clk_out) |-> ##[9:13] $rose(master_clk_out))
        else $error("master clock low phase out of range");
    chk_apb_error: assert property (
        psel && penable && pready |-> pslverr == unmapped)
        else $error("apb error flag wrong");
    chk_apb_wait: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer missing after wait state");
endmodule

bind mcc_top mcc_top_props #(.NUM_CH(NUM_CH)) u_props (.mclk_in, .sys_rst_in, .psel, .penable,
    .paddr, .pready, .pslverr, .strap_in, .hw_mode_in, .host_port_select_in,
    .serial_host_out_oe_out, .master_clk_out, .output_rate_select_out,
    .serial_port_active_out, .chan_cfg_out);

// file: tb/mcc_ref_model.sv
// model: external reference clock sources
`timescale 1ns/1ps
module mcc_ref_model
    import mcc_pkg::*;
(
    // selection
    input wire logic [2:0] ref_freq_select_in,
    input wire logic single_src_in,
    // reference clocks
    output logic e1_ref_clock_out,
    output logic t1_ref_clock_out
);
    logic t1_own = 1'b0;
    function automatic int unsigned ref_khz(input logic [2:0] s, input logic one);
        case (s)
            MCC_SEL_HI_T1: return one ? MCC_T1_KHZ : MCC_E1_KHZ;
            MCC_SEL_8K: return 8;
            MCC_SEL_16K: return 16;
            MCC_SEL_56K: return 56;
            MCC_SEL_64K: return 64;
            MCC_SEL_128K: return 128;
            MCC_SEL_256K: return 256;
            default: return MCC_E1_KHZ;
        endcase
    endfunction
    initial begin
        e1_ref_clock_out = 1'b0;
        forever begin
            #(500000.0 / ref_khz(ref_freq_select_in, single_src_in));
            e1_ref_clock_out = ~e1_ref_clock_out;
        end
    end
    initial forever #(500000.0 / MCC_T1_KHZ) t1_own = ~t1_own;
    // one source feeds both inputs when single_src_in is high; codes other than 001 leave t1 unused
    assign t1_ref_clock_out = single_src_in ? e1_ref_clock_out : t1_own;
endmodule

// file: tb/mcc_top_tb.sv
// testbench: apb, serial and strap scenarios for the master clock block
`timescale 1ns/1ps
module mcc_top_tb;
    import mcc_pkg::*;
    logic mclk_in = 0, sys_rst_in = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, v;
    logic e1_ref_clock_in, t1_ref_clock_in, hw_mode_in = 0, host_port_select_in = 0;
    logic serial_host_clk_in = 0, serial_host_in = 0, serial_host_out, serial_host_out_oe_out;
    logic master_clk_out, output_rate_select_out, serial_port_active_out, single_src = 0;
    mcc_strap_t strap_in = '0, st;
    mcc_chan_cfg_t [7:0] chan_cfg_out;
    logic [31:0] exp_q[$];
    logic [31:0] vals[8];
    logic [15:0] got;
    logic [31:0] ctl;
    int num_errors = 0, tests_run = 0, cycles = 0, n, cnt, ekhz;
    mcc_top #(.NUM_CH(8)) uut (.mclk_in, .sys_rst_in, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .e1_ref_clock_in, .t1_ref_clock_in, .strap_in, .hw_mode_in,
        .host_port_select_in, .serial_host_clk_in, .serial_host_in, .serial_host_out,
        .serial_host_out_oe_out, .master_clk_out, .output_rate_select_out,
        .serial_port_active_out, .chan_cfg_out);
    mcc_ref_model u_ref (.ref_freq_select_in(strap_in.ref_freq_select), .single_src_in(single_src),
        .e1_ref_clock_out(e1_ref_clock_in), .t1_ref_clock_out(t1_ref_clock_in));
    initial forever #12.5 mclk_in = ~mclk_in;
    // ==========================================
    // shared tasks
    // ==========================================
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("errors=%0d comparisons=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
        @(posedge mclk_in);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_in);
        penable <= 1;
        // request held until pready is seen high at a rising edge
        do begin
            @(posedge mclk_in);
        end while (pready !== 1'b1);
        check(32'(pslverr), 32'(err));
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
        exp_q.push_back(e);
        apb(1'b0, a, '0, err);
    endtask
    // read data taken at the edge that sees pready high
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            final_report();
        end
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
            check(prdata, exp_q.pop_front());
        end
    end
    // ==========================================
    // main sequence
    // ==========================================
    initial begin
        void'($urandom(32'h5649));
        repeat (2) @(posedge mclk_in);
        sys_rst_in <= 0;
        rd(MCC_ADDR_CTRL, MCC_CTRL_RST, 0);
        v = {19'h0, 5'($urandom), 1'b0, 3'($urandom), 3'h0, 1'b1};
        ctl = v;
        apb(1, MCC_ADDR_CTRL, v, 0);
        rd(MCC_ADDR_CTRL, v, 0);
        for (int i = 0; i < 8; i++) begin
            vals[i] = $urandom & 32'h0003_ffff;
            if (i == 0) vals[i][17:15] = MCC_LB_DUAL;
            apb(1, 8'(MCC_ADDR_CH_BASE + 4 * i), vals[i], 0);
        end
        for (int i = 0; i < 8; i++) begin
            rd(8'(MCC_ADDR_CH_BASE + 4 * i), vals[i], 0);
            v = vals[i];
            check(32'(chan_cfg_out[i]), 32'({v[1:0], v[3:2], v[5:4], v[6], v[7], v[12],
                ctl[MCC_CTRL_EQC + MCC_EQC_E1_BIT], v[10:8], (v[14:13] == MCC_PAT_TRANSMIT_ALL_ONES),
                (v[14:13] == MCC_PAT_QRSS), v[17:15]}));
        end
        rd(8'h08, 32'h0, 1);
        apb(1, 8'h30, 32'hffff_ffff, 1);
        rd(8'h30, 32'h0, 1);
        host_port_select_in <= 1;
        repeat (2) @(posedge mclk_in);
        check(32'(serial_port_active_out), 32'h1);
        n = 0;
        got = '0;
        for (int k = 0; k < 24; k++) begin
            serial_host_in <= (k < 8) ? 1'(8'h43 >> (7 - k)) : 1'($urandom);
            serial_host_clk_in <= 0;
            repeat (4) @(posedge mclk_in);
            if (serial_host_out_oe_out === 1'b1) begin
                got = {got[14:0], serial_host_out};
                n++;
            end
            serial_host_clk_in <= 1;
            repeat (4) @(posedge mclk_in);
        end
        serial_host_clk_in <= 0;
        check(32'(got), vals[3] & 32'h0000_ffff);
        check(32'(n), 32'd16);
        hw_mode_in <= 1;
        repeat (2) @(posedge mclk_in);
        check(32'(serial_port_active_out), 32'h0);
        apb(1, MCC_ADDR_CH_BASE, 32'h0002_4000, 0);
        for (int s = 0; s < 16; s++) begin
            st = mcc_strap_t'($urandom);
            st.ref_freq_select = 3'(s >> 1);
            st.equalizer_control[MCC_EQC_E1_BIT] = s[0];
            strap_in <= st;
            single_src <= 1'($urandom);
            repeat (400) @(posedge mclk_in);
            check(32'(output_rate_select_out), 32'(!s[0]));
            for (int i = 0; i < 8; i++) check(32'(chan_cfg_out[i][17:4]), 32'(st[16:3]));
            check(32'(chan_cfg_out[0][3:0]), 32'h0);
            ekhz = (s[0] ? MCC_E1_KHZ : MCC_T1_KHZ) / 20;
            cnt = 0;
            v[0] = master_clk_out;
            repeat (2000) begin
                @(posedge mclk_in);
                if (master_clk_out === 1'b1 && v[0] === 1'b0) cnt++;
                v[0] = master_clk_out;
            end
            check(32'(cnt >= ekhz && cnt <= ekhz + 1), 32'h1);
        end
        final_report();
    end
endmodule
